// ### verif/uhs_modem_model.sv
// Behavioural modem on the control lines of the host select block
module uhs_modem_model (
    input wire logic core_clk,
    input wire logic dtr_n,
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n,
    output logic host_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ******************************************
    // Line levels, inactive until told otherwise
    // ******************************************
    initial begin
        cts_n = 1'b1;
        dsr_n = 1'b1;
        dcd_n = 1'b1;
    end
    // Ready as the modem sees it, active low pin
    assign host_ready = ~dtr_n;
    // Lines move just after a falling edge, away from sampling
    task automatic drive(input logic c, input logic s, input logic d);
        @(negedge core_clk);
        cts_n = c;
        dsr_n = s;
        dcd_n = d;
    endtask
endmodule

// ### verif/uhs_top_test.sv
// Self-checking bench for the host select block
`include "uhs_defs.svh"
module uhs_top_test
    import uhs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, sel_a, sel_b, sel_c, strobe_n, rd_n, wr_n;
    logic [2:0] idx;
    logic [7:0] din, eng_rd, data_out, engine_wdata, last_wd, d;
    logic rx_err, rx_av, rx_to, thr_e, data_oe, xcvr_off_n, dtr_n, tx_ok, irq, erp, ewp;
    logic cts_n, dsr_n, dcd_n, host_ready;
    logic [2:0] eaddr;
    int error_cnt = 0;
    int n_compared = 0;
    int n_wpulse = 0;
    int pc;
    uhs_top i_dut (.core_clk(core_clk), .rst(rst), .select_high_a(sel_a),
        .select_high_b(sel_b), .select_low_c(sel_c), .addr_latch_strobe_n(strobe_n),
        .reg_select(idx), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .data_in(din),
        .data_out(data_out), .data_oe(data_oe), .transceiver_off_n(xcvr_off_n),
        .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .dtr_n(dtr_n), .tx_allowed(tx_ok),
        .irq(irq), .rx_error(rx_err), .rx_data_avail(rx_av), .rx_timeout(rx_to),
        .thr_empty(thr_e), .engine_rd_data(eng_rd), .engine_rd_pulse(erp),
        .engine_wr_pulse(ewp), .engine_addr(eaddr), .engine_wdata(engine_wdata));
    uhs_modem_model i_modem (.core_clk(core_clk), .dtr_n(dtr_n), .cts_n(cts_n),
        .dsr_n(dsr_n), .dcd_n(dcd_n), .host_ready(host_ready));
    // ******************************************
    // Clock, write pulse monitor, helpers
    // ******************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Counts committed writes and keeps their data
    always @(posedge core_clk) begin
        if (ewp === 1'b1) begin
            n_wpulse <= n_wpulse + 1;
            last_wd <= engine_wdata;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Host write: strobe held four cycles, then released
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge core_clk);
        idx = a;
        din = v;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(5);
        din = ~v;
    endtask
    // Host read: 8'hee stands for no answer at all
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        int n;
        @(negedge core_clk);
        idx = a;
        rd_n = 1'b0;
        n = 0;
        while (data_oe !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        v = (n < 8) ? data_out : 8'hee;
        if (n < 8) chk("transceiver_off_n in read", 8'h01, {7'h0, xcvr_off_n});
        if (n < 8) chk("engine_rd_pulse", 8'h01, {7'h0, erp});
        rd_n = 1'b1;
        cyc(5);
        chk("transceiver_off_n idle", 8'h00, {7'h0, xcvr_off_n});
        chk("data_oe idle", 8'h00, {7'h0, data_oe});
    endtask
    // Raise one interrupt source, see the flag and its code, then service it
    task automatic src_chk(input logic [7:0] ier, input logic [3:0] src, input logic [7:0] code);
        bus_wr(`UHS_ADDR_IER, ier);
        {rx_err, rx_av, rx_to, thr_e} = src;
        cyc(4);
        chk("irq raised", 8'h01, {7'h0, irq});
        bus_rd(`UHS_ADDR_IIR_FCR, d);
        chk("iir", code, d);
        {rx_err, rx_av, rx_to, thr_e} = 4'h0;
        cyc(4);
        chk("irq serviced", 8'h00, {7'h0, irq});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        $display("watchdog expired");
        tally_and_finish();
    end
    // ******************************************
    // Test sequence
    // ******************************************
    initial begin
        {rst, sel_a, sel_b, sel_c, strobe_n, rd_n, wr_n} = 7'b1110011;
        {rx_err, rx_av, rx_to, thr_e} = 4'h0;
        idx = 3'h0;
        din = 8'h00;
        eng_rd = 8'h5a;
        cyc(20);
        rst = 1'b0;
        cyc(3);
        chk("dtr_n reset", 8'h01, {7'h0, dtr_n});
        chk("irq reset", 8'h00, {7'h0, irq});
        $display("test reset done");
        // Every select combination, only one of them opens the bus
        for (int i = 0; i < 8; i++) begin
            {sel_a, sel_b, sel_c} = i[2:0];
            pc = n_wpulse;
            bus_wr(3'h7, 8'(i + 8'h30));
            chk("write pulses", (i == 6) ? 8'h01 : 8'h00, 8'(n_wpulse - pc));
            if (i == 6) chk("engine_wdata", 8'h36, last_wd);
            bus_rd(3'h7, d);
            chk("engine read", (i == 6) ? eng_rd : 8'hee, d);
        end
        {sel_a, sel_b, sel_c} = 3'b110;
        $display("test select done");
        // Strobe high holds select and index taken at its rise
        idx = 3'h7;
        cyc(3);
        strobe_n = 1'b1;
        cyc(1);
        sel_c = 1'b1;
        bus_rd(`UHS_ADDR_MCR, d);
        chk("latched read", eng_rd, d);
        chk("engine_addr latched", 8'h07, {5'h0, eaddr});
        strobe_n = 1'b0;
        sel_c = 1'b0;
        $display("test strobe done");
        // DTR follows its control bit unless loopback is on
        bus_wr(`UHS_ADDR_MCR, 8'h01);
        chk("dtr set", 8'h01, {7'h0, host_ready});
        bus_wr(`UHS_ADDR_MCR, 8'h11);
        chk("dtr loop", 8'h01, {7'h0, dtr_n});
        bus_wr(`UHS_ADDR_MCR, 8'h01);
        chk("dtr again", 8'h00, {7'h0, dtr_n});
        bus_wr(`UHS_ADDR_MCR, 8'h00);
        chk("dtr cleared", 8'h01, {7'h0, dtr_n});
        $display("test dtr done");
        // Modem status levels and change flags
        bus_rd(`UHS_ADDR_MSR, d);
        chk("msr idle", 8'h00, d);
        i_modem.drive(1'b0, 1'b1, 1'b0);
        cyc(5);
        bus_rd(`UHS_ADDR_MSR, d);
        chk("msr cts dcd", 8'h99, d);
        bus_rd(`UHS_ADDR_MSR, d);
        chk("msr after read", 8'h90, d);
        i_modem.drive(1'b0, 1'b0, 1'b0);
        cyc(5);
        bus_rd(`UHS_ADDR_MSR, d);
        chk("msr dsr", 8'hb2, d);
        i_modem.drive(1'b1, 1'b1, 1'b1);
        cyc(5);
        bus_rd(`UHS_ADDR_MSR, d);
        chk("msr all released", 8'h0b, d);
        $display("test msr done");
        // Modem interrupts, auto flow gating, reset mid-run
        bus_wr(`UHS_ADDR_IER, 8'h08);
        chk("irq quiet", 8'h00, {7'h0, irq});
        i_modem.drive(1'b1, 1'b0, 1'b1);
        cyc(6);
        chk("irq dsr", 8'h01, {7'h0, irq});
        bus_rd(`UHS_ADDR_IIR_FCR, d);
        chk("iir modem", 8'h00, d);
        bus_rd(`UHS_ADDR_MSR, d);
        chk("irq after msr read", 8'h00, {7'h0, irq});
        bus_rd(`UHS_ADDR_IIR_FCR, d);
        chk("iir none", 8'h01, d);
        i_modem.drive(1'b1, 1'b0, 1'b0);
        cyc(6);
        chk("irq dcd", 8'h01, {7'h0, irq});
        bus_rd(`UHS_ADDR_MSR, d);
        bus_wr(`UHS_ADDR_MCR, 8'h20);
        chk("tx gated", 8'h00, {7'h0, tx_ok});
        i_modem.drive(1'b0, 1'b0, 1'b0);
        cyc(6);
        chk("irq auto cts", 8'h00, {7'h0, irq});
        chk("tx open", 8'h01, {7'h0, tx_ok});
        bus_wr(`UHS_ADDR_MCR, 8'h00);
        bus_rd(`UHS_ADDR_MSR, d);
        i_modem.drive(1'b1, 1'b0, 1'b0);
        cyc(6);
        chk("irq cts", 8'h01, {7'h0, irq});
        chk("tx no gate", 8'h01, {7'h0, tx_ok});
        bus_wr(`UHS_ADDR_MCR, 8'h01);
        rst = 1'b1;
        cyc(4);
        chk("irq master reset", 8'h00, {7'h0, irq});
        chk("dtr master reset", 8'h01, {7'h0, dtr_n});
        rst = 1'b0;
        cyc(3);
        bus_rd(`UHS_ADDR_MSR, d);
        $display("test modem irq done");
        // Timeout only with the FIFO mode on, then every source but modem
        bus_wr(`UHS_ADDR_IER, 8'h01);
        rx_to = 1'b1;
        cyc(4);
        chk("timeout no fifo", 8'h00, {7'h0, irq});
        rx_to = 1'b0;
        bus_wr(`UHS_ADDR_IIR_FCR, 8'h01);
        src_chk(8'h01, 4'b0010, 8'hcc);
        src_chk(8'h01, 4'b0100, 8'hc4);
        src_chk(8'h04, 4'b1000, 8'hc6);
        src_chk(8'h02, 4'b0001, 8'hc2);
        bus_rd(`UHS_ADDR_IER, d);
        chk("ier readback", 8'h02, d);
        thr_e = 1'b1;
        cyc(4);
        chk("irq thr again", 8'h01, {7'h0, irq});
        bus_wr(`UHS_ADDR_DATA, 8'h5c);
        chk("irq data write", 8'h00, {7'h0, irq});
        chk("engine_addr write", 8'h00, {5'h0, eaddr});
        thr_e = 1'b0;
        bus_wr(`UHS_ADDR_IER, 8'h00);
        rx_av = 1'b1;
        cyc(4);
        chk("irq masked", 8'h00, {7'h0, irq});
        rx_av = 1'b0;
        $display("test sources done");
        tally_and_finish();
    end
endmodule

// ### verilog/uhs_defs.svh
// Offsets, field positions, reset values and codes of the host select block
`ifndef UHS_DEFS_SVH
`define UHS_DEFS_SVH

// ***************************************************************
// Register indices on reg_select
// ***************************************************************
`define UHS_ADDR_DATA 3'h0
`define UHS_ADDR_IER 3'h1
`define UHS_ADDR_IIR_FCR 3'h2
`define UHS_ADDR_MCR 3'h4
`define UHS_ADDR_MSR 3'h6

// ***************************************************************
// Field positions
// ***************************************************************
`define UHS_IER_RX_DATA 0
`define UHS_IER_THR_EMPTY 1
`define UHS_IER_LINE 2
`define UHS_IER_MODEM 3
`define UHS_FCR_FIFO_EN 0
`define UHS_MCR_DTR 0
`define UHS_MCR_LOOP 4
`define UHS_MCR_AUTO_FLOW 5
`define UHS_MSR_DCTS 0
`define UHS_MSR_DDSR 1
`define UHS_MSR_DDCD 3
`define UHS_MSR_CTS 4
`define UHS_MSR_DSR 5
`define UHS_MSR_DCD 7

// ***************************************************************
// Reset values and identification codes
// ***************************************************************
`define UHS_IER_RST 8'h00
`define UHS_MCR_RST 8'h00
`define UHS_IIR_NONE 4'h1
`define UHS_IIR_LINE 4'h6
`define UHS_IIR_RX_DATA 4'h4
`define UHS_IIR_TIMEOUT 4'hc
`define UHS_IIR_THR 4'h2
`define UHS_IIR_MODEM 4'h0
`define UHS_IIR_FIFO_BITS 2'h3

`endif

// ### verilog/uhs_pkg.sv
// Types shared by the host select block
package uhs_pkg;
    typedef enum logic [2:0] {
        UHS_IDLE = 3'b001,
        UHS_READ = 3'b010,
        UHS_WRITE = 3'b100
    } uhs_bus_e;
    typedef logic [7:0] uhs_byte_t;
endpackage

// ### verilog/uhs_sync2.sv
// Two-stage synchroniser for pin inputs
module uhs_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ### verilog/uhs_top.sv
// Host select, bus access, modem signals and interrupt output of the UART
//
// Behaviour
// - Selected only when high_a, high_b high, low_c low
// - Any select inactive: ignore reads and writes
// - Strobe low passes selects; high holds latched
// - Eight-bit two-way data path, three-state outputs
// - Modem status bits 4,5,7 show CTS,DSR,DCD
// - Bits 0,1,3 flag changes since last read
// - CTS change interrupts only without auto flow
// - DSR or DCD change interrupts when enabled
// - Auto flow: CTS gates the transmitter
// - Transceiver disable low except during reads
// - DTR control bit drives DTR low
// - DTR inactive on reset, loopback, cleared bit
// - Interrupt output high while anything pending
// - Sources: line error, rx data/timeout, THR, modem
// - Receive timeout only counts in FIFO mode
// - Interrupt drops when serviced or on reset
`include "uhs_defs.svh"

module uhs_top
    import uhs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic select_high_a,
    input wire logic select_high_b,
    input wire logic select_low_c,
    input wire logic addr_latch_strobe_n,
    input wire logic [2:0] reg_select,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic transceiver_off_n,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic dcd_n,
    output logic dtr_n,
    output logic tx_allowed,
    output logic irq,
    input wire logic rx_error,
    input wire logic rx_data_avail,
    input wire logic rx_timeout,
    input wire logic thr_empty,
    input wire logic [7:0] engine_rd_data,
    output logic engine_rd_pulse,
    output logic engine_wr_pulse,
    output logic [2:0] engine_addr,
    output logic [7:0] engine_wdata
);

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    logic [8:0] bus_ctl_s;
    logic [7:0] data_s;
    logic [2:0] modem_n_s;

    // Strobes idle high, select pins idle as deselected
    uhs_sync2 #(.W(9), .RST_VAL(9'h1e1)) u_sync_ctl (
        .core_clk(core_clk),
        .rst(rst),
        .d({wr_strobe_n, rd_strobe_n, addr_latch_strobe_n, select_low_c,
            select_high_b, select_high_a, reg_select}),
        .q(bus_ctl_s)
    );

    uhs_sync2 #(.W(8), .RST_VAL(8'h00)) u_sync_data (
        .core_clk(core_clk),
        .rst(rst),
        .d(data_in),
        .q(data_s)
    );

    uhs_sync2 #(.W(3), .RST_VAL(3'h7)) u_sync_modem (
        .core_clk(core_clk),
        .rst(rst),
        .d({dcd_n, dsr_n, cts_n}),
        .q(modem_n_s)
    );

    // ***************************************************************
    // Select decode and address latch
    // ***************************************************************
    logic sel_live;
    logic as_low;
    logic sel_eff;
    logic [2:0] addr_eff;
    logic lat_sel_reg;
    logic [2:0] lat_addr_reg;
    logic wr_n_s;
    logic rd_n_s;
    logic rd_req;
    logic wr_req;

    // Live decode of the three selects
    assign sel_live = bus_ctl_s[3] & bus_ctl_s[4] & ~bus_ctl_s[5];
    assign as_low = ~bus_ctl_s[6];
    assign rd_n_s = bus_ctl_s[7];
    assign wr_n_s = bus_ctl_s[8];
    assign sel_eff = as_low ? sel_live : lat_sel_reg;
    assign addr_eff = as_low ? bus_ctl_s[2:0] : lat_addr_reg;
    assign rd_req = sel_eff & ~rd_n_s;
    assign wr_req = sel_eff & ~wr_n_s;

    // Latch follows while strobe low, freezes at its rising edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lat_sel_reg <= 1'b0;
            lat_addr_reg <= 3'h0;
        end else if (as_low) begin
            lat_sel_reg <= sel_live;
            lat_addr_reg <= bus_ctl_s[2:0];
        end
    end

    // ***************************************************************
    // Internal registers
    // ***************************************************************
    logic [7:0] ier_reg;
    logic [7:0] mcr_reg;
    logic fifo_mode_reg;
    logic auto_cts;
    logic loop_mode;

    assign auto_cts = mcr_reg[`UHS_MCR_AUTO_FLOW];
    assign loop_mode = mcr_reg[`UHS_MCR_LOOP];

    // ***************************************************************
    // Modem levels and change flags
    // ***************************************************************
    logic cts_lvl;
    logic dsr_lvl;
    logic dcd_lvl;
    logic [2:0] lvl_prev_reg;
    logic dcts_reg;
    logic ddsr_reg;
    logic ddcd_reg;
    logic msr_rd;
    logic [7:0] msr_val;

    // Active (low) pin reads as one
    assign cts_lvl = ~modem_n_s[0];
    assign dsr_lvl = ~modem_n_s[1];
    assign dcd_lvl = ~modem_n_s[2];
    assign msr_val = {dcd_lvl, 1'b0, dsr_lvl, cts_lvl,
                      ddcd_reg, 1'b0, ddsr_reg, dcts_reg};

    // Change flags: a change in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lvl_prev_reg <= 3'h0;
            dcts_reg <= 1'b0;
            ddsr_reg <= 1'b0;
            ddcd_reg <= 1'b0;
        end else begin
            lvl_prev_reg <= {dcd_lvl, dsr_lvl, cts_lvl};
            dcts_reg <= (cts_lvl != lvl_prev_reg[0]) | (dcts_reg & ~msr_rd);
            ddsr_reg <= (dsr_lvl != lvl_prev_reg[1]) | (ddsr_reg & ~msr_rd);
            ddcd_reg <= (dcd_lvl != lvl_prev_reg[2]) | (ddcd_reg & ~msr_rd);
        end
    end

    // ***************************************************************
    // Interrupt sources and identification
    // ***************************************************************
    logic thr_prev_reg;
    logic thr_int_reg;
    logic modem_pend;
    logic line_pend;
    logic rx_pend;
    logic tmo_pend;
    logic thr_pend;
    logic any_pend;
    logic [3:0] iir_code;
    logic iir_rd;
    logic data_wr;

    assign modem_pend = ier_reg[`UHS_IER_MODEM]
                        & ((dcts_reg & ~auto_cts) | ddsr_reg | ddcd_reg);
    assign line_pend = ier_reg[`UHS_IER_LINE] & rx_error;
    assign rx_pend = ier_reg[`UHS_IER_RX_DATA] & rx_data_avail;
    assign tmo_pend = ier_reg[`UHS_IER_RX_DATA] & rx_timeout & fifo_mode_reg;
    assign thr_pend = ier_reg[`UHS_IER_THR_EMPTY] & thr_int_reg;
    assign any_pend = line_pend | rx_pend | tmo_pend | thr_pend | modem_pend;

    // Highest priority source names the interrupt
    assign iir_code = line_pend ? `UHS_IIR_LINE :
                      rx_pend ? `UHS_IIR_RX_DATA :
                      tmo_pend ? `UHS_IIR_TIMEOUT :
                      thr_pend ? `UHS_IIR_THR :
                      modem_pend ? `UHS_IIR_MODEM : `UHS_IIR_NONE;

    // Empty holding register: set on edge, cleared by service
    always_ff @(posedge core_clk) begin
        if (rst) begin
            thr_prev_reg <= 1'b0;
            thr_int_reg <= 1'b0;
        end else begin
            thr_prev_reg <= thr_empty;
            thr_int_reg <= (thr_empty & ~thr_prev_reg)
                           | (thr_int_reg & ~data_wr
                              & ~(iir_rd & (iir_code == `UHS_IIR_THR)));
        end
    end

    // ***************************************************************
    // Host bus access state machine
    // ***************************************************************
    uhs_bus_e state_reg;
    uhs_bus_e state_next;
    logic [2:0] acc_addr_reg;
    logic [7:0] rd_mux;
    logic rd_start;
    logic wr_done;

    assign rd_start = (state_reg == UHS_IDLE) & rd_req;
    assign wr_done = (state_reg == UHS_WRITE) & wr_n_s;
    assign msr_rd = rd_start & (addr_eff == `UHS_ADDR_MSR);
    assign iir_rd = rd_start & (addr_eff == `UHS_ADDR_IIR_FCR);
    assign data_wr = wr_done & (acc_addr_reg == `UHS_ADDR_DATA);

    // Read data selection
    assign rd_mux = (addr_eff == `UHS_ADDR_IER) ? ier_reg :
                    (addr_eff == `UHS_ADDR_IIR_FCR) ?
                        {(fifo_mode_reg ? `UHS_IIR_FIFO_BITS : 2'h0), 2'h0, iir_code} :
                    (addr_eff == `UHS_ADDR_MCR) ? mcr_reg :
                    (addr_eff == `UHS_ADDR_MSR) ? msr_val : engine_rd_data;

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            UHS_IDLE: begin
                if (rd_req) begin
                    state_next = UHS_READ;
                end else if (wr_req) begin
                    state_next = UHS_WRITE;
                end
            end
            UHS_READ: begin
                if (rd_n_s) begin
                    state_next = UHS_IDLE;
                end
            end
            UHS_WRITE: begin
                if (wr_n_s) begin
                    state_next = UHS_IDLE;
                end
            end
            default: begin
                state_next = UHS_IDLE;
            end
        endcase
    end

    // State, access address and write data capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= UHS_IDLE;
            acc_addr_reg <= 3'h0;
            engine_wdata <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == UHS_IDLE) begin
                acc_addr_reg <= addr_eff;
            end
            if (state_reg == UHS_WRITE && !wr_n_s) begin
                engine_wdata <= data_s;
            end
        end
    end

    // Read drive: data and transceiver control follow the read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            transceiver_off_n <= 1'b0;
        end else begin
            if (rd_start) begin
                data_out <= rd_mux;
            end
            data_oe <= (state_next == UHS_READ);
            transceiver_off_n <= (state_next == UHS_READ);
        end
    end

    // Register writes and engine strobes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ier_reg <= `UHS_IER_RST;
            mcr_reg <= `UHS_MCR_RST;
            fifo_mode_reg <= 1'b0;
            engine_rd_pulse <= 1'b0;
            engine_wr_pulse <= 1'b0;
            engine_addr <= 3'h0;
        end else begin
            engine_rd_pulse <= rd_start;
            engine_wr_pulse <= wr_done;
            if (rd_start) begin
                engine_addr <= addr_eff;
            end else if (wr_done) begin
                engine_addr <= acc_addr_reg;
            end
            if (wr_done && acc_addr_reg == `UHS_ADDR_IER) begin
                ier_reg <= {4'h0, engine_wdata[3:0]};
            end
            if (wr_done && acc_addr_reg == `UHS_ADDR_MCR) begin
                mcr_reg <= engine_wdata;
            end
            if (wr_done && acc_addr_reg == `UHS_ADDR_IIR_FCR) begin
                fifo_mode_reg <= engine_wdata[`UHS_FCR_FIFO_EN];
            end
        end
    end

    // ***************************************************************
    // Modem outputs, transmit gate and interrupt pin
    // ***************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dtr_n <= 1'b1;
            tx_allowed <= 1'b1;
            irq <= 1'b0;
        end else begin
            dtr_n <= ~(mcr_reg[`UHS_MCR_DTR] & ~loop_mode);
            tx_allowed <= ~auto_cts | cts_lvl;
            irq <= any_pend;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_sel_decode;
        $rose(data_oe) |-> $past(sel_eff);
    endproperty
    a_sel_decode: assert property (p_sel_decode) else $error("read without select");

    property p_desel_quiet;
        (state_reg == UHS_IDLE && !sel_eff) |=> !data_oe && !engine_wr_pulse;
    endproperty
    a_desel_quiet: assert property (p_desel_quiet) else $error("access while deselected");

    property p_latch_hold;
        (!as_low && $past(!as_low)) |-> (sel_eff == $past(sel_eff));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched select moved");

    property p_xcvr_idle;
        (state_reg == UHS_IDLE && !rd_req) |=> !transceiver_off_n;
    endproperty
    a_xcvr_idle: assert property (p_xcvr_idle) else $error("disable high outside read");

    property p_cts_change;
        (cts_lvl != lvl_prev_reg[0]) |=> dcts_reg [*2] or (dcts_reg ##1 $past(msr_rd));
    endproperty
    a_cts_change: assert property (p_cts_change) else $error("cts change lost");

    property p_msr_clear;
        (msr_rd && cts_lvl == lvl_prev_reg[0] && dsr_lvl == lvl_prev_reg[1]
         && dcd_lvl == lvl_prev_reg[2]) |=> !dcts_reg && !ddsr_reg && !ddcd_reg;
    endproperty
    a_msr_clear: assert property (p_msr_clear) else $error("flags kept after read");

    property p_auto_cts_int;
        (auto_cts && !ddsr_reg && !ddcd_reg) |-> !modem_pend;
    endproperty
    a_auto_cts_int: assert property (p_auto_cts_int) else $error("cts int in auto mode");

    property p_dsr_int;
        (ier_reg[`UHS_IER_MODEM] && ddsr_reg) |-> ##1 irq;
    endproperty
    a_dsr_int: assert property (p_dsr_int) else $error("dsr change no irq");

    property p_tx_gate;
        (auto_cts && !cts_lvl) |=> !tx_allowed;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx not gated");

    property p_dtr_loop;
        loop_mode |=> dtr_n;
    endproperty
    a_dtr_loop: assert property (p_dtr_loop) else $error("dtr active in loop");

    property p_dtr_on;
        (mcr_reg[`UHS_MCR_DTR] && !loop_mode) |=> !dtr_n;
    endproperty
    a_dtr_on: assert property (p_dtr_on) else $error("dtr not driven");

    property p_no_tmo;
        !fifo_mode_reg |-> (iir_code != `UHS_IIR_TIMEOUT);
    endproperty
    a_no_tmo: assert property (p_no_tmo) else $error("timeout outside fifo mode");

    property p_irq_follow;
        !any_pend |=> !irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq held w/o source");

endmodule
